// file: rtl/sw_sync2.sv
`timescale 1ns/10ps
module sw_sync2 #(
    parameter int WIDTH = 1
) (
    // clock and reset
    input  wire logic             i_sys_clk,
    input  wire logic             i_arst_n,
    // data
    input  wire logic [WIDTH-1:0] i_async,
    output logic      [WIDTH-1:0] o_sync
);
    logic [WIDTH-1:0] meta_reg;

    always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            meta_reg <= '0;
            o_sync   <= '0;
        end else begin
            meta_reg <= i_async;
            o_sync   <= meta_reg;
        end
    end
endmodule

// file: rtl/switch_reset_refclk_strap_ctrl.sv
`timescale 1ns/10ps
module switch_reset_refclk_strap_ctrl (
    // clock and reset
    input  wire logic         i_sys_clk,
    input  wire logic         i_arst_n,
    // system reset pin (asynchronous, active low)
    input  wire logic         i_system_reset_n,
    // software l2/l3 recovery reset request per downstream port
    input  wire logic [5:1]   i_sw_port_reset,
    // software refclk disable per output
    input  wire logic [7:1]   i_sw_refclk_disable,
    // straps and clock requests
    input  wire logic         i_refclk_buffer_powerdown_strap,
    input  wire logic         i_output_swing_select_strap,
    input  wire logic [7:1]   i_port_clock_request_n,
    // lane groups, receive side
    input  wire logic [11:0]  i_lane_rx_pos,
    input  wire logic [11:0]  i_lane_rx_neg,
    // lane groups, transmit side from ports
    input  wire logic [3:0]   i_port0_tx_pos,
    input  wire logic [3:0]   i_port0_tx_neg,
    input  wire logic [3:0]   i_port1_tx_pos,
    input  wire logic [3:0]   i_port1_tx_neg,
    input  wire logic [5:2]   i_single_tx_pos,
    input  wire logic [5:2]   i_single_tx_neg,
    // downstream resets
    output logic [5:1]        o_downstream_port_reset_n,
    // buffered reference clock and internal reset
    output logic [7:1]        o_refclk_out_enable,
    output logic              o_swing_700mv,
    output logic              o_refclk_buffer_enable,
    output logic              o_internal_reset_n,
    // lanes, port side
    output logic [3:0]        o_port0_rx_pos,
    output logic [3:0]        o_port0_rx_neg,
    output logic [3:0]        o_port1_rx_pos,
    output logic [3:0]        o_port1_rx_neg,
    output logic [5:2]        o_single_rx_pos,
    output logic [5:2]        o_single_rx_neg,
    // lanes, pin side
    output logic [11:0]       o_lane_tx_pos,
    output logic [11:0]       o_lane_tx_neg
);

    ////////////////////////////////////////////////////////////////////////
    // synchronisers
    logic        sysrst_sync;
    logic        pd_sync;
    logic        swing_sync;
    logic [7:1]  creq_n_sync;

    sw_sync2 #(.WIDTH(10)) u_sync (
        .i_sys_clk (i_sys_clk),
        .i_arst_n  (i_arst_n),
        .i_async   ({i_system_reset_n, i_refclk_buffer_powerdown_strap,
                     i_output_swing_select_strap, i_port_clock_request_n}),
        .o_sync    ({sysrst_sync, pd_sync, swing_sync, creq_n_sync})
    );

    // sync pipeline filled: strap and request levels trusted after two edges
    logic [1:0] sync_fill_reg;
    logic       straps_valid;

    always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            sync_fill_reg <= 2'h0;
        end else begin
            sync_fill_reg <= {sync_fill_reg[0], 1'b1};
        end
    end

    assign straps_valid = sync_fill_reg[1];

    ////////////////////////////////////////////////////////////////////////
    // reset sequencer
    sw_reset_pkg::seq_state_t state_reg;
    logic [2:0]               cnt_reg;

    always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            state_reg <= sw_reset_pkg::ST_HOLD;
            cnt_reg   <= 3'h0;
        end else if (!sysrst_sync) begin
            state_reg <= sw_reset_pkg::ST_HOLD;
            cnt_reg   <= 3'h0;
        end else begin
            case (state_reg)
                sw_reset_pkg::ST_HOLD: begin
                    state_reg <= sw_reset_pkg::ST_SETTLE;
                    cnt_reg   <= 3'h0;
                end
                sw_reset_pkg::ST_SETTLE: begin
                    if (cnt_reg == sw_reset_pkg::RELEASE_CYCLES - 3'h1) begin
                        state_reg <= sw_reset_pkg::ST_RUN;
                    end
                    cnt_reg <= cnt_reg + 3'h1;
                end
                sw_reset_pkg::ST_RUN: begin
                    state_reg <= sw_reset_pkg::ST_RUN;
                end
                default: begin
                    state_reg <= sw_reset_pkg::ST_HOLD;
                end
            endcase
        end
    end

    wire running = (state_reg == sw_reset_pkg::ST_RUN);

    ////////////////////////////////////////////////////////////////////////
    // downstream resets and internal reset
    always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_downstream_port_reset_n <= sw_reset_pkg::DOWN_RST_RESET;
            o_internal_reset_n        <= 1'b0;
        end else begin
            o_downstream_port_reset_n <= running ? ~i_sw_port_reset : sw_reset_pkg::DOWN_RST_RESET;
            o_internal_reset_n        <= running;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // strap sampling and refclk gating
    always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_refclk_buffer_enable <= 1'b0;
            o_swing_700mv          <= 1'b0;
            o_refclk_out_enable    <= sw_reset_pkg::REFCLK_OFF;
        end else begin
            // refclks stay off until the synchronisers hold real pin levels
            o_refclk_buffer_enable <= straps_valid & ~pd_sync;
            o_swing_700mv          <= swing_sync;
            if (pd_sync || !straps_valid) begin
                o_refclk_out_enable <= sw_reset_pkg::REFCLK_OFF;
            end else begin
                o_refclk_out_enable <= ~creq_n_sync & ~i_sw_refclk_disable;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // lane grouping, registered
    always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_port0_rx_pos  <= 4'h0;
            o_port0_rx_neg  <= 4'h0;
            o_port1_rx_pos  <= 4'h0;
            o_port1_rx_neg  <= 4'h0;
            o_single_rx_pos <= 4'h0;
            o_single_rx_neg <= 4'h0;
            o_lane_tx_pos   <= 12'h000;
            o_lane_tx_neg   <= 12'h000;
        end else begin
            o_port0_rx_pos  <= i_lane_rx_pos[3:0];
            o_port0_rx_neg  <= i_lane_rx_neg[3:0];
            o_port1_rx_pos  <= i_lane_rx_pos[7:4];
            o_port1_rx_neg  <= i_lane_rx_neg[7:4];
            o_single_rx_pos <= i_lane_rx_pos[11:8];
            o_single_rx_neg <= i_lane_rx_neg[11:8];
            o_lane_tx_pos   <= {i_single_tx_pos, i_port1_tx_pos, i_port0_tx_pos};
            o_lane_tx_neg   <= {i_single_tx_neg, i_port1_tx_neg, i_port0_tx_neg};
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // assertions
    a_rst_hold: assert property (@(posedge i_sys_clk) disable iff (!i_arst_n)
        !sysrst_sync |=> ##1 (o_downstream_port_reset_n == 5'h00))
        else $error("downstream reset not held during system reset");
    a_rst_release: assert property (@(posedge i_sys_clk) disable iff (!i_arst_n)
        $rose(sysrst_sync) |-> (o_downstream_port_reset_n == 5'h00) [*5])
        else $error("downstream reset released too early");
    a_rst_run: assert property (@(posedge i_sys_clk) disable iff (!i_arst_n)
        $rose(running) |=> o_downstream_port_reset_n == ~$past(i_sw_port_reset))
        else $error("downstream reset wrong after release");
    a_sw_reset: assert property (@(posedge i_sys_clk) disable iff (!i_arst_n)
        (running && i_sw_port_reset[3]) |=> !o_downstream_port_reset_n[3])
        else $error("software port reset not applied");
    a_int_reset: assert property (@(posedge i_sys_clk) disable iff (!i_arst_n)
        !sysrst_sync |=> ##1 !o_internal_reset_n)
        else $error("internal reset not asserted");
    a_pd_off: assert property (@(posedge i_sys_clk) disable iff (!i_arst_n)
        pd_sync |=> (o_refclk_out_enable == 7'h00) && !o_refclk_buffer_enable)
        else $error("refclk outputs on while powered down");
    a_creq_on: assert property (@(posedge i_sys_clk) disable iff (!i_arst_n)
        (straps_valid && !pd_sync && !creq_n_sync[1] && !i_sw_refclk_disable[1]) |=> o_refclk_out_enable[1])
        else $error("requested refclk output not enabled");
    a_swing_sel: assert property (@(posedge i_sys_clk) disable iff (!i_arst_n)
        ##1 o_swing_700mv == $past(swing_sync))
        else $error("swing level not following strap");
    a_lane_map: assert property (@(posedge i_sys_clk) disable iff (!i_arst_n)
        ##1 (o_port1_rx_pos == $past(i_lane_rx_pos[7:4])) && (o_single_rx_pos[2] == $past(i_lane_rx_pos[8])))
        else $error("lane grouping wrong");

    c_release:  cover property (@(posedge i_sys_clk) disable iff (!i_arst_n) $rose(running));
    c_sw_rst:   cover property (@(posedge i_sys_clk) disable iff (!i_arst_n) running && |i_sw_port_reset);
    c_pd:       cover property (@(posedge i_sys_clk) disable iff (!i_arst_n) pd_sync && running);
endmodule

// file: shared/sw_reset_pkg.sv
package sw_reset_pkg;
    // port and lane counts
    localparam int NUM_DOWN_PORTS   = 5;
    localparam int NUM_REFCLK_OUTS  = 7;
    localparam int NUM_LANES        = 12;
    localparam int NUM_PORTS        = 6;
    // lane grouping for the two wide ports and the single-lane ports
    localparam int PORT0_LANE_LO    = 0;
    localparam int PORT1_LANE_LO    = 4;
    localparam int WIDE_PORT_LANES  = 4;
    localparam int SINGLE_LANE_BASE = 8;
    // reference clock rate and swing levels (mV)
    localparam int REFCLK_MHZ       = 100;
    localparam int SWING_HIGH_MV    = 700;
    localparam int SWING_LOW_MV     = 400;
    // reset values
    localparam logic [4:0] DOWN_RST_RESET = 5'h00;
    localparam logic [6:0] REFCLK_OFF     = 7'h00;
    // release delay after system reset deasserts, in cycles
    localparam logic [2:0] RELEASE_CYCLES = 3'h4;

    typedef enum logic [1:0] {
        ST_HOLD    = 2'b00,
        ST_SETTLE  = 2'b01,
        ST_RUN     = 2'b11
    } seq_state_t;
endpackage

// file: tb/host_platform_model.sv
`timescale 1ns/10ps
module host_platform_model (
    // clock
    input  wire logic       i_sys_clk,
    // bench commands
    input  wire logic       i_hold_reset,
    input  wire logic [7:1] i_want_clk,
    // pins toward the switch
    output logic            o_system_reset_n,
    output logic [7:1]      o_port_clock_request_n
);
    initial begin
        o_system_reset_n       = 1'b0;
        o_port_clock_request_n = 7'h7F;
    end
    always @(posedge i_sys_clk) begin
        o_system_reset_n       <= ~i_hold_reset;
        o_port_clock_request_n <= ~i_want_clk;
    end
endmodule

// file: tb/switch_reset_refclk_strap_ctrl_bench.sv
`timescale 1ns/10ps
module switch_reset_refclk_strap_ctrl_bench;
    logic        i_sys_clk, i_arst_n, hold, pd, swg, sw700, bufen, irst_n, srst_n;
    logic [5:1]  swr, dn_n;
    logic [7:1]  dis, want, req_n, en;
    logic [11:0] rxp, rxn, txp, txn;
    logic [3:0]  a_tp, a_tn, b_tp, b_tn, a_rp, a_rn, b_rp, b_rn;
    logic [5:2]  s_tp, s_tn, s_rp, s_rn;
    logic [31:0] seed;
    int          failures, checked;

    initial begin
        i_sys_clk = 1'b0;
        forever #5 i_sys_clk = ~i_sys_clk;
    end

    host_platform_model partner (.i_sys_clk(i_sys_clk), .i_hold_reset(hold), .i_want_clk(want),
        .o_system_reset_n(srst_n), .o_port_clock_request_n(req_n));

    switch_reset_refclk_strap_ctrl uut (.i_sys_clk(i_sys_clk), .i_arst_n(i_arst_n),
        .i_system_reset_n(srst_n), .i_sw_port_reset(swr), .i_sw_refclk_disable(dis),
        .i_refclk_buffer_powerdown_strap(pd), .i_output_swing_select_strap(swg),
        .i_port_clock_request_n(req_n), .i_lane_rx_pos(rxp), .i_lane_rx_neg(rxn),
        .i_port0_tx_pos(a_tp), .i_port0_tx_neg(a_tn), .i_port1_tx_pos(b_tp), .i_port1_tx_neg(b_tn),
        .i_single_tx_pos(s_tp), .i_single_tx_neg(s_tn), .o_downstream_port_reset_n(dn_n),
        .o_refclk_out_enable(en), .o_swing_700mv(sw700), .o_refclk_buffer_enable(bufen),
        .o_internal_reset_n(irst_n), .o_port0_rx_pos(a_rp), .o_port0_rx_neg(a_rn),
        .o_port1_rx_pos(b_rp), .o_port1_rx_neg(b_rn), .o_single_rx_pos(s_rp), .o_single_rx_neg(s_rn),
        .o_lane_tx_pos(txp), .o_lane_tx_neg(txn));

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    function automatic logic [6:0] exp_en(input logic p, input logic [6:0] r_n, input logic [6:0] d);
        return p ? 7'h00 : (~r_n & ~d);
    endfunction
    function automatic logic [11:0] exp_tx(input logic [3:0] a, input logic [3:0] b, input logic [3:0] s);
        return {s, b, a};
    endfunction

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            failures++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic print_verdict;
        if (failures == 0 && checked > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    task automatic wait_release;
        int n;
        n = 0;
        while (dn_n !== 5'h1F && n < 40) begin
            @(posedge i_sys_clk);
            #1;
            n++;
        end
        #1;
        if (n == 40) begin
            check("release timeout", 32'h1, 32'h0);
            print_verdict();
        end
    endtask

    initial begin
        {i_arst_n, hold, pd, swg, swr, dis, want, rxp, rxn} = '0;
        {a_tp, a_tn, b_tp, b_tn, s_tp, s_tn} = '0;
        seed = 32'h48A6FB39;
        failures = 0;
        checked = 0;
        repeat (3) @(posedge i_sys_clk);
        #1;
        check("reset outs", {dn_n, en, bufen, irst_n}, 32'h0);
        repeat (3) @(posedge i_sys_clk);
        i_arst_n <= 1'b1;
        wait_release();
        for (int i = 0; i < 40; i++) begin
            @(posedge i_sys_clk);
            seed = lfsr(lfsr(seed));
            pd   <= (i == 0) ? 1'b1 : (i == 1) ? 1'b0 : seed[0] & seed[1];
            want <= (i < 2) ? 7'h7F : seed[8:2];
            dis  <= (i < 2) ? 7'h00 : seed[15:9] & seed[22:16];
            swr  <= (i == 1) ? 5'h1F : seed[27:23];
            swg  <= seed[28];
            rxp  <= seed[11:0];
            rxn  <= seed[31:20];
            seed = lfsr(lfsr(lfsr(seed)));
            {a_tp, a_tn, b_tp, b_tn, s_tp, s_tn} <= seed[23:0];
            repeat (6) @(posedge i_sys_clk);
            #1;
            check("refclk enables", en, exp_en(pd, req_n, dis));
            check("buffer enable", bufen, {~pd});
            check("swing", sw700, swg);
            check("down resets", dn_n, {~swr});
            check("rx wide", {b_rp, b_rn, a_rp, a_rn}, {rxp[7:4], rxn[7:4], rxp[3:0], rxn[3:0]});
            check("rx single", {s_rp, s_rn}, {rxp[11:8], rxn[11:8]});
            check("tx pos", txp, exp_tx(a_tp, b_tp, s_tp));
            check("tx neg", txn, exp_tx(a_tn, b_tn, s_tn));
        end
        @(posedge i_sys_clk);
        swr  <= 5'h00;
        hold <= 1'b1;
        repeat (6) @(posedge i_sys_clk);
        #1;
        check("resets in sys reset", {dn_n, irst_n}, 6'h00);
        @(posedge i_sys_clk);
        hold <= 1'b0;
        repeat (5) @(posedge i_sys_clk);
        #1;
        check("early release", dn_n, 5'h00);
        wait_release();
        check("internal release", irst_n, 1'b1);
        print_verdict();
    end
endmodule
